// >>> pkg/tlip_pkg.sv
// package of constants and types for the two-level interrupt priority controller
package tlip_pkg;

    // ************************************************************
    // sizes
    // ************************************************************
    localparam int NUM_SOURCES = 16;                 // distinct interrupt sources
    localparam int VEC_WIDTH   = 16;                 // handler address width

    // ************************************************************
    // reset values
    // ************************************************************
    localparam logic [7:0]  PRIO_FIRST_RESET  = 8'h00;     // all low after reset
    localparam logic [7:0]  PRIO_SECOND_RESET = 8'h00;     // all low after reset
    localparam logic [15:0] ENABLE_RESET      = 16'h0000;  // all sources masked
    localparam logic [15:0] PENDING_RESET     = 16'h0000;  // nothing pending

    // ************************************************************
    // timing: one cycle to detect, four for the long call
    // ************************************************************
    localparam int DETECT_CYCLES    = 1;
    localparam int LONG_CALL_CYCLES = 4;
    localparam logic [2:0] CALL_COUNT_LAST = 3'(LONG_CALL_CYCLES - 1);

    // ************************************************************
    // default vector table (handler address = 0x0003 + 8*index)
    // and default same-level order (index 0 ranks first)
    // ************************************************************
    localparam logic [15:0] VECTOR_BASE = 16'h0003;
    localparam logic [15:0] VECTOR_STEP = 16'h0008;

    // state of the vectoring sequencer
    typedef enum logic [3:0] {
        TLIP_IDLE = 4'b0001,   // watching for a request
        TLIP_CALL = 4'b0010,   // long call in progress
        TLIP_RET  = 4'b0100,   // return seen, one instruction must finish
        TLIP_HOLD = 4'b1000    // waiting for that instruction to end
    } tlip_state_type;

    // request presented to the core
    typedef struct packed {
        logic                   valid;   // call in progress
        logic                   high;    // level of the source called
        logic [3:0]             source;  // source index
        logic [VEC_WIDTH-1:0]   vector;  // handler address
    } tlip_call_type;

endpackage

// >>> src/tlip_controller.sv
// two-level interrupt priority controller with vectoring toward the cpu core
`timescale 1ns/1ps

// How it works
// - sixteen sources, own flag, vector, rank
// - software-set flag requests like hardware
// - vector to the winning source's handler
// - each source low or high level
// - high request preempts running low handler
// - nothing preempts a running high handler
// - one priority bit per source, two registers
// - all sources low priority after reset
// - high level wins simultaneous mixed requests
// - fixed rank breaks same-level ties
// - decode every cycle, four-cycle call
// - one instruction after return before call
// - equal-or-lower level waits return plus instruction
module tlip_controller #(
    // rank order: entry k holds the source index with rank k (0 best)
    parameter logic [63:0]  RANK_ORDER = 64'hFEDC_BA98_7654_3210,
    // handler address per source, source 0 in the low bits
    parameter logic [255:0] VECTORS    = {
        16'h007B, 16'h0073, 16'h006B, 16'h0063, 16'h005B, 16'h0053, 16'h004B, 16'h0043,
        16'h003B, 16'h0033, 16'h002B, 16'h0023, 16'h001B, 16'h0013, 16'h000B, 16'h0003}
) (
    // clock and reset
    input  wire logic                         ref_clk,
    input  wire logic                         reset,
    // event sources and software writes
    input  wire logic [15:0]                  hwEvent,         // one-cycle hardware set pulses
    input  wire logic [15:0]                  swSetPending,    // software writes a one
    input  wire logic [15:0]                  swClearPending,  // software writes a zero
    // configuration
    input  wire logic                         globalEnable,
    input  wire logic [15:0]                  sourceEnable,
    input  wire logic                         prioWriteFirst,  // load first priority register
    input  wire logic                         prioWriteSecond, // load second priority register
    input  wire logic [7:0]                   prioWriteData,
    // cpu core handshake
    input  wire logic                         instrDone,       // pulse: an instruction completed
    input  wire logic                         returnFromHandler, // pulse: return executed
    // outputs toward the core and software
    output tlip_pkg::tlip_call_type           callReq,
    output logic [15:0]                       pending,
    output logic [7:0]                        priorityLevelBitsFirst,
    output logic [7:0]                        priorityLevelBitsSecond,
    output logic [1:0]                        activeLevels     // bit1 high running, bit0 low running
);
    import tlip_pkg::*;

    // ************************************************************
    // pending flags and priority registers
    // ************************************************************
    logic [15:0] next_pending;
    logic [7:0]  next_prioFirst;
    logic [7:0]  next_prioSecond;
    logic [15:0] level;          // one per source, 1 = high
    logic [15:0] req;            // qualified requests

    // arbitration results live here: the flag logic below clears the winner's flag
    // when its call starts, so they must be declared before that process
    logic        winValid;       // some qualified request exists
    logic        winHigh;        // the winner sits at the high level
    logic [3:0]  winSrc;         // index of the winning source
    logic        startCall;      // a call to the winner begins this cycle

    // flags: set beats clear, taken flag cleared on call start
    always_comb begin
        next_pending    = pending & ~swClearPending;
        next_pending    = next_pending | hwEvent | swSetPending;
        next_prioFirst  = prioWriteFirst  ? prioWriteData : priorityLevelBitsFirst;
        next_prioSecond = prioWriteSecond ? prioWriteData : priorityLevelBitsSecond;
        if (startCall) begin
            // hardware clears the serviced flag; a fresh event still wins
            next_pending[winSrc] = hwEvent[winSrc] | swSetPending[winSrc];
        end
    end

    // register flags and priority bits
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            pending                 <= PENDING_RESET;
            priorityLevelBitsFirst  <= PRIO_FIRST_RESET;
            priorityLevelBitsSecond <= PRIO_SECOND_RESET;
        end else begin
            pending                 <= next_pending;
            priorityLevelBitsFirst  <= next_prioFirst;
            priorityLevelBitsSecond <= next_prioSecond;
        end
    end

    // bit i of the pair is source i; the second register covers sources 8 to 15
    assign level = {priorityLevelBitsSecond, priorityLevelBitsFirst};
    assign req   = pending & sourceEnable & {16{globalEnable}};

    // ************************************************************
    // arbitration, re-evaluated each cycle
    // ************************************************************
    // scan the rank table; high level beats any low, rank breaks ties
    // two passes cost a little logic but keep the level rule obvious
    always_comb begin
        logic [3:0] idx;
        idx      = 4'h0;
        winValid = 1'b0;
        winHigh  = 1'b0;
        winSrc   = 4'h0;
        for (int k = NUM_SOURCES - 1; k >= 0; k--) begin
            idx = RANK_ORDER[4*k +: 4];
            if (req[idx] && level[idx]) begin
                winValid = 1'b1;
                winHigh  = 1'b1;
                winSrc   = idx;
            end
        end
        if (!winValid) begin
            for (int k = NUM_SOURCES - 1; k >= 0; k--) begin
                idx = RANK_ORDER[4*k +: 4];
                if (req[idx]) begin
                    winValid = 1'b1;
                    winSrc   = idx;
                end
            end
        end
    end

    // ************************************************************
    // vectoring sequencer and handler nesting
    // ************************************************************
    tlip_state_type state;
    tlip_state_type next_state;
    tlip_call_type  next_callReq;
    logic [2:0]     callCount;
    logic [2:0]     next_callCount;
    logic [1:0]     next_activeLevels;
    logic           canPreempt;      // winner may enter above the running level

    // a request may enter only above the running level
    always_comb begin
        if (activeLevels[1])
            canPreempt = 1'b0;
        else if (activeLevels[0])
            canPreempt = winHigh;
        else
            canPreempt = 1'b1;
        // a return in the same cycle takes the idle slot; starting now would clear
        // the winner's flag although no call follows
        startCall = (state == TLIP_IDLE) && winValid && canPreempt && !returnFromHandler;
    end

    // next state; the return path forces one instruction before a call
    // limitation: a return is only heard in idle; the core never returns mid-call
    always_comb begin
        next_state        = state;
        next_callReq      = callReq;
        next_callCount    = callCount;
        next_activeLevels = activeLevels;
        case (state)
            TLIP_IDLE: begin
                if (returnFromHandler) begin
                    // the innermost level ends: high if running, else low
                    if (activeLevels[1])
                        next_activeLevels[1] = 1'b0;
                    else
                        next_activeLevels[0] = 1'b0;
                    next_state = TLIP_RET;
                end else if (startCall) begin
                    next_callReq.valid  = 1'b1;
                    next_callReq.high   = winHigh;
                    next_callReq.source = winSrc;
                    next_callReq.vector = VECTORS[16*winSrc +: 16];
                    next_callCount      = 3'h0;
                    next_state          = TLIP_CALL;
                    if (winHigh)
                        next_activeLevels[1] = 1'b1;
                    else
                        next_activeLevels[0] = 1'b1;
                end
            end
            TLIP_CALL: begin
                // hold the call for the long-call cycles
                if (callCount == CALL_COUNT_LAST) begin
                    next_callReq.valid = 1'b0;
                    next_state         = TLIP_IDLE;
                end else begin
                    next_callCount = callCount + 3'h1;
                end
            end
            TLIP_RET: begin
                // the return itself may still report done; skip it
                next_state = TLIP_HOLD;
            end
            TLIP_HOLD: begin
                // one more instruction must complete before any call
                if (instrDone)
                    next_state = TLIP_IDLE;
            end
            default: begin
                next_state = TLIP_IDLE;
            end
        endcase
    end

    // register the sequencer; reset drops any call in flight and all nesting
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            state        <= TLIP_IDLE;
            callReq      <= '0;
            callCount    <= 3'h0;
            activeLevels <= 2'b00;
        end else begin
            state        <= next_state;
            callReq      <= next_callReq;
            callCount    <= next_callCount;
            activeLevels <= next_activeLevels;
        end
    end

endmodule

// >>> bench/tlip_core_model.sv
// behavioural cpu core: return pulses and instruction-end pulses
`timescale 1ns/1ps
module tlip_core_model #(
    parameter int GAP = 3  // cycles per instruction, large for a slow core
) (
    // clock and reset
    input  wire logic ref_clk,
    input  wire logic reset,
    // bench command and core outputs
    input  wire logic retCmd,
    output logic      instrDone,
    output logic      returnFromHandler
);
    int count;  // cycles into the current instruction
    // instructions end every GAP cycles, one return pulse per command
    always_ff @(posedge ref_clk) begin
        count <= (reset || count == GAP - 1) ? 0 : count + 1;
        instrDone <= !reset && count == GAP - 1;
        returnFromHandler <= !reset && retCmd;
    end
endmodule

// >>> bench/tlip_props.sv
// checker for the two-level interrupt priority controller
`timescale 1ns/1ps
module tlip_props #(
    parameter logic [255:0] VECTORS = 256'h0
) (
    // clock and reset
    input wire logic               ref_clk,
    input wire logic               reset,
    // enables and core return
    input wire logic               globalEnable,
    input wire logic [15:0]        sourceEnable,
    input wire logic               returnFromHandler,
    // controller outputs
    input tlip_pkg::tlip_call_type callReq,
    input wire logic [15:0]        pending,
    input wire logic [7:0]         priorityLevelBitsFirst,
    input wire logic [7:0]         priorityLevelBitsSecond,
    input wire logic [1:0]         activeLevels
);
    import tlip_pkg::*;
    logic [15:0] lvl;   // level bit per source
    logic [15:0] qual;  // requests that may reach arbitration
    assign lvl = {priorityLevelBitsSecond, priorityLevelBitsFirst};
    assign qual = pending & sourceEnable & {16{globalEnable}};
    default clocking @(posedge ref_clk); endclocking
    default disable iff (reset);
    property p_len; $rose(callReq.valid) |-> callReq.valid[*4] ##1 !callReq.valid; endproperty
    a_len: assert property (p_len) else $error("call length wrong");
    property p_vec; callReq.valid |-> callReq.vector == VECTORS[callReq.source*16 +: 16]; endproperty
    a_vec: assert property (p_vec) else $error("wrong vector");
    property p_high; activeLevels[1] && !returnFromHandler |=> !$rose(callReq.valid); endproperty
    a_high: assert property (p_high) else $error("high handler preempted");
    property p_low; $rose(callReq.valid) && $past(activeLevels[0]) |-> callReq.high; endproperty
    a_low: assert property (p_low) else $error("low handler preempted by low");
    property p_lvl; $rose(callReq.valid) |-> callReq.high == lvl[callReq.source]; endproperty
    a_lvl: assert property (p_lvl) else $error("call level wrong");
    property p_qual; $rose(callReq.valid) |-> (($past(qual) >> callReq.source) & 16'h0001) != 16'h0000; endproperty
    a_qual: assert property (p_qual) else $error("unqualified call");
    property p_rst; disable iff (1'b0) reset |=> !callReq.valid && activeLevels == 2'b00 && lvl == 16'h0000;
    endproperty
    a_rst: assert property (p_rst) else $error("reset state wrong");
    property p_ret; returnFromHandler |=> (!$rose(callReq.valid))[*2]; endproperty
    a_ret: assert property (p_ret) else $error("call too soon after return");
    c_call: cover property ($rose(callReq.valid));
    c_ret: cover property (returnFromHandler);
    c_pre: cover property ($rose(callReq.valid) && $past(activeLevels[0]) && callReq.high);
endmodule
bind tlip_controller tlip_props #(.VECTORS(VECTORS)) u_props (.ref_clk(ref_clk), .reset(reset),
    .globalEnable(globalEnable), .sourceEnable(sourceEnable), .returnFromHandler(returnFromHandler),
    .callReq(callReq), .pending(pending), .priorityLevelBitsFirst(priorityLevelBitsFirst),
    .priorityLevelBitsSecond(priorityLevelBitsSecond), .activeLevels(activeLevels));

// >>> bench/testbench.sv
// self-checking bench for the two-level interrupt priority controller
`timescale 1ns/1ps
module testbench;
    import tlip_pkg::*;
    logic          ref_clk = 1'b0;
    logic          reset = 1'b1;
    logic          globalEnable = 1'b0;
    logic          retCmd = 1'b0;
    logic          prioWrite = 1'b0;
    logic          prioWrFirst = 1'b0;
    logic [7:0]    prioData = 8'h00;
    logic [15:0]   hwEvent = 16'h0000;
    logic [15:0]   swSet = 16'h0000;
    logic [15:0]   srcEn = 16'hFFDF;  // source 5 masked at first
    logic          instrDone;
    logic          returnFromHandler;
    tlip_call_type callReq;
    logic [15:0]   pending;
    logic [7:0]    prioFirst;
    logic [7:0]    prioSecond;
    logic [1:0]    activeLevels;
    int            mismatches = 0;
    int            testsRun = 0;
    tlip_controller DUT (.ref_clk(ref_clk), .reset(reset), .hwEvent(hwEvent), .swSetPending(swSet),
        .swClearPending(16'h0000), .globalEnable(globalEnable), .sourceEnable(srcEn), .prioWriteFirst(prioWrFirst),
        .prioWriteSecond(prioWrite), .prioWriteData(prioData), .instrDone(instrDone),
        .returnFromHandler(returnFromHandler), .callReq(callReq), .pending(pending),
        .priorityLevelBitsFirst(prioFirst), .priorityLevelBitsSecond(prioSecond), .activeLevels(activeLevels));
    tlip_core_model #(.GAP(3)) core (.ref_clk(ref_clk), .reset(reset), .retCmd(retCmd),
        .instrDone(instrDone), .returnFromHandler(returnFromHandler));
    initial forever #25 ref_clk = ~ref_clk;
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", testsRun, mismatches);
        if (mismatches == 0 && testsRun > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task automatic check(input string what, input logic [21:0] exp, input logic [21:0] got);
        testsRun++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    // bounded wait for the next call, then judge it
    task automatic expect_call(input logic [3:0] src, input logic high);
        int n;
        n = 0;
        while (callReq.valid !== 1'b1 && n < 40) begin
            @(posedge ref_clk);
            #1;
            n++;
        end
        if (n == 40) begin
            check("call wait", 22'h1, 22'h0);
            print_verdict();
        end else begin
            check("source", 22'(src), 22'(callReq.source));
            check("vector", 22'(VECTOR_BASE + VECTOR_STEP * 16'(src)), 22'(callReq.vector));
            check("level", 22'(high), 22'(callReq.high));
        end
    endtask
    // a given source must not be called for n cycles
    task automatic quiet(input logic [3:0] src, input int n);
        repeat (n) begin
            @(posedge ref_clk);
            #1;
            check("no call", 22'h0, 22'(callReq.valid && callReq.source == src));
        end
    endtask
    task automatic raise(input logic [15:0] mask, input logic hw);
        @(posedge ref_clk);
        if (hw) hwEvent <= mask;
        else swSet <= mask;
        @(posedge ref_clk);
        hwEvent <= 16'h0000;
        swSet <= 16'h0000;
    endtask
    // waits out the running call before returning
    task automatic ret();
        repeat (5) @(posedge ref_clk);
        retCmd <= 1'b1;
        @(posedge ref_clk);
        retCmd <= 1'b0;
    endtask
    task automatic test_enables();
        raise(16'h0020, 1'b0);
        quiet(4'h5, 8);
        check("pending", 22'h20, 22'(pending));
        @(posedge ref_clk);
        globalEnable <= 1'b1;
        quiet(4'h5, 8);
        @(posedge ref_clk);
        srcEn <= 16'hFFFF;
        expect_call(4'h5, 1'b0);
        ret();
    endtask
    task automatic test_tie();
        raise(16'h0204, 1'b1);
        expect_call(4'h2, 1'b0);
        ret();
        expect_call(4'h9, 1'b0);
        ret();
    endtask
    task automatic test_levels();
        @(posedge ref_clk);
        prioWrite <= 1'b1;
        prioData <= 8'h10;
        @(posedge ref_clk);
        prioWrite <= 1'b0;
        @(posedge ref_clk);
        #1;
        check("second levels", 22'h10, 22'(prioSecond));
        raise(16'h1002, 1'b0);
        expect_call(4'hC, 1'b1);
        check("active", 22'h2, 22'(activeLevels));
        raise(16'h0001, 1'b1);
        quiet(4'h0, 10);
        ret();
        expect_call(4'h0, 1'b0);
        check("active", 22'h1, 22'(activeLevels));
        quiet(4'h1, 8);
        raise(16'h1000, 1'b1);
        expect_call(4'hC, 1'b1);
        check("active", 22'h3, 22'(activeLevels));
        ret();
        quiet(4'h1, 10);
        ret();
        expect_call(4'h1, 1'b0);
    endtask
    // first priority register: source 3 goes high and preempts the low handler
    task automatic test_first();
        @(posedge ref_clk);
        prioWrFirst <= 1'b1;
        prioData <= 8'h08;
        @(posedge ref_clk);
        prioWrFirst <= 1'b0;
        @(posedge ref_clk);
        #1;
        check("first levels", 22'h08, 22'(prioFirst));
        raise(16'h0008, 1'b0);
        expect_call(4'h3, 1'b1);
        check("active", 22'h3, 22'(activeLevels));
    endtask
    initial begin
        repeat (20) @(posedge ref_clk);
        reset <= 1'b0;
        @(posedge ref_clk);
        #1;
        check("levels", 22'h0, {6'h0, prioSecond, prioFirst});
        test_enables();
        test_tie();
        test_levels();
        test_first();
        print_verdict();
    end
endmodule
